// File: core/frp_fetch_if.sv
// fetch origin tracking interface between top and classifier
`timescale 1ns/1ps
`default_nettype none
interface frp_fetch_if;
  logic                fetchValid;
  logic [23:0]         fetchAddr;
  frp_pkg::frp_origin_t origin;
  modport src (output fetchValid, output fetchAddr, input origin);
  modport cls (input fetchValid, input fetchAddr, output origin);
endinterface : frp_fetch_if
`default_nettype wire

// File: core/frp_flash_read_protection.sv
// flash read protection top: filters cpu data access to the flash
// ==========================================================
// Functional notes
// - protected data reads of flash allowed only from code fetched in flash
// - branches into and out of flash pass unchanged
// - program and erase refused while protected
// - fuse at 1 gives protection after every reset
// - fuse unprogrammed value 0 leaves flash unprotected
// - fuse reachable only in special programming mode
// - protected reads from non-flash code return B88B
// - kernel call while protected ends with error code 01
// - zero word written to even flash address lifts protection
// - zero write lifts protection only from flash-fetched code
// - deprotected: true data returned, kernel commands accepted
// - kernel completion restores protection when fuse set
`timescale 1ns/1ps
`default_nettype none
`include "frp_params.svh"
module frp_flash_read_protection #(
  parameter int ADDR_W = `FRP_ADDR_W,
  parameter int DATA_W = `FRP_DATA_W
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              fetchValid,
  input  wire logic [ADDR_W-1:0] fetchAddr,
  input  wire logic              dataRd,
  input  wire logic              dataWr,
  input  wire logic [ADDR_W-1:0] dataAddr,
  input  wire logic [DATA_W-1:0] dataWdata,
  input  wire logic [DATA_W-1:0] flashRdata,
  output logic [DATA_W-1:0]      cpuRdata,
  output logic                   cpuRvalid,
  input  wire logic              kernelStart,
  input  wire logic              kernelOpDone,
  output logic                   kernelGo,
  output logic                   kernelDone,
  output logic [7:0]             kernelErr,
  input  wire logic              specialMode,
  input  wire logic              fuseWrEn,
  input  wire logic              fuseWrData,
  output logic                   fuseRdata,
  output logic                   protActive
);
  // ==========================================================
  // elaboration checks
  // the region decode and the pattern are fixed to a 24-bit address and 16-bit word
  if (ADDR_W != 24 || DATA_W != 16) begin : g_bad_width
    $error("frp: only 24-bit address and 16-bit data supported");
  end

  function automatic logic frpIsFlash(input logic [ADDR_W-1:0] a);
    frpIsFlash = (a >= `FRP_FLASH_BASE) && (a <= `FRP_FLASH_LIMIT);
  endfunction : frpIsFlash

  // ==========================================================
  // fetch origin
  frp_fetch_if fif ();
  assign fif.fetchValid = fetchValid;
  assign fif.fetchAddr  = fetchAddr;
  frp_origin u_origin (
    .core_clk (core_clk),
    .rst      (rst),
    .fif      (fif)
  );
  logic fromFlash;
  assign fromFlash = (fif.origin == frp_pkg::FRP_ORG_FLASH);

  // ==========================================================
  // one-time fuse, only reachable in special mode
  // the cell is non-volatile: reset must not clear it, or a set fuse
  // could never protect the flash after the next reset
  logic fuse_r = `FRP_FUSE_RESET; // unprogrammed cell

  // set-only write, refused outside special mode and during reset
  always_ff @(posedge core_clk) begin
    if (!rst && specialMode && fuseWrEn && fuseWrData) begin
      fuse_r <= 1'h1;
    end
  end
  assign fuseRdata = specialMode ? fuse_r : 1'h0;

  // ==========================================================
  // protection state
  logic armed_r;
  logic prot_r;
  logic unlockHit;
  frp_pkg::frp_kstate_t kst_r;
  // zero word to an even flash address, issued by flash code
  assign unlockHit = dataWr && frpIsFlash(dataAddr) && !dataAddr[0]
                   && (dataWdata == 16'h0000) && fromFlash;

  // arm one cycle after reset so the fuse is sampled clocked
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      armed_r <= 1'h0;
    end else begin
      armed_r <= 1'h1;
    end
  end

  // protect at reset release, lift on unlock, rearm on kernel end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prot_r <= 1'h0;
    end else if (!armed_r) begin
      prot_r <= fuse_r;
    end else if (kst_r == frp_pkg::FRP_K_DONE) begin
      prot_r <= fuse_r;
    end else if (unlockHit) begin
      prot_r <= 1'h0;
    end
  end
  assign protActive = prot_r;

  // ==========================================================
  // read filter; fetches are never filtered
  logic blockRead;
  assign blockRead = prot_r && !fromFlash && frpIsFlash(dataAddr);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cpuRdata  <= 16'h0000;
      cpuRvalid <= 1'h0;
    end else begin
      cpuRvalid <= dataRd;
      if (dataRd) begin
        cpuRdata <= blockRead ? `FRP_PROT_PATTERN : flashRdata;
      end
    end
  end

  // ==========================================================
  // kernel gate
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      kst_r     <= frp_pkg::FRP_K_IDLE;
      kernelErr <= `FRP_ERR_NONE;
    end else begin
      case (kst_r)
        frp_pkg::FRP_K_IDLE: begin
          // calls before arming are ignored so the fuse is seen first
          if (kernelStart && armed_r) begin
            kernelErr <= prot_r ? `FRP_ERR_PROT : `FRP_ERR_NONE;
            kst_r     <= prot_r ? frp_pkg::FRP_K_DONE : frp_pkg::FRP_K_RUN;
          end
        end
        frp_pkg::FRP_K_RUN: begin
          if (kernelOpDone) begin
            kst_r <= frp_pkg::FRP_K_DONE;
          end
        end
        frp_pkg::FRP_K_DONE: kst_r <= frp_pkg::FRP_K_IDLE;
        default: kst_r <= frp_pkg::FRP_K_IDLE;
      endcase
    end
  end
  // array operation only runs while unprotected
  assign kernelGo   = (kst_r == frp_pkg::FRP_K_RUN) && !prot_r;
  assign kernelDone = (kst_r == frp_pkg::FRP_K_DONE);

  // ==========================================================
  // assertions
  // protected flash read by non-flash code
  sequence s_blocked_rd;
    dataRd && prot_r && !fromFlash && frpIsFlash(dataAddr);
  endsequence
  property p_pattern;
    @(posedge core_clk) disable iff (rst)
      s_blocked_rd |=> (cpuRdata == 16'hB88B) && cpuRvalid;
  endproperty
  a_pattern: assert property (p_pattern) else $error("protected read leaked data");

  // flash code always reads the true array word
  property p_flash_code_rd;
    @(posedge core_clk) disable iff (rst)
      (dataRd && fromFlash) |=> cpuRdata == $past(flashRdata);
  endproperty
  a_flash_code_rd: assert property (p_flash_code_rd) else $error("flash code read altered");

  // unprotected reads pass the array word
  property p_unprot_rd;
    @(posedge core_clk) disable iff (rst)
      (dataRd && !prot_r) |=> cpuRdata == $past(flashRdata);
  endproperty
  a_unprot_rd: assert property (p_unprot_rd) else $error("unprotected read altered");

  // no array operation, and no running kernel, while protected
  property p_no_go;
    @(posedge core_clk) disable iff (rst)
      prot_r |-> !kernelGo && (kst_r != frp_pkg::FRP_K_RUN);
  endproperty
  a_no_go: assert property (p_no_go) else $error("array op while protected");

  // protected kernel call ends at once with the protection code
  property p_err01;
    @(posedge core_clk) disable iff (rst)
      (kst_r == frp_pkg::FRP_K_IDLE && kernelStart && prot_r)
        |=> kernelDone && kernelErr == 8'h01;
  endproperty
  a_err01: assert property (p_err01) else $error("protected kernel call not refused");

  // accepted zero write lifts protection next cycle
  property p_unlock;
    @(posedge core_clk) disable iff (rst)
      (armed_r && unlockHit && kst_r != frp_pkg::FRP_K_DONE) |=> !prot_r;
  endproperty
  a_unlock: assert property (p_unlock) else $error("zero write did not unprotect");

  // writes from non-flash code leave protection set
  property p_no_ram_unlock;
    @(posedge core_clk) disable iff (rst)
      (prot_r && dataWr && !fromFlash && kst_r != frp_pkg::FRP_K_DONE) |=> prot_r;
  endproperty
  a_no_ram_unlock: assert property (p_no_ram_unlock) else $error("ram code unprotected");

  // kernel end reloads protection from the fuse
  property p_rearm;
    @(posedge core_clk) disable iff (rst) kernelDone |=> prot_r == $past(fuse_r);
  endproperty
  a_rearm: assert property (p_rearm) else $error("protection not restored");

  // first edge after reset loads protection from the fuse
  property p_reset_prot;
    @(posedge core_clk) disable iff (rst) !armed_r |=> prot_r == $past(fuse_r);
  endproperty
  a_reset_prot: assert property (p_reset_prot) else $error("reset protection wrong");

  // fuse reads as zero outside special mode
  property p_fuse_hidden;
    @(posedge core_clk) disable iff (rst) !specialMode |-> fuseRdata == 1'b0;
  endproperty
  a_fuse_hidden: assert property (p_fuse_hidden) else $error("fuse visible");

  // read answered in the cycle after the request
  property p_rvalid;
    @(posedge core_clk) disable iff (rst) dataRd |=> cpuRvalid;
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");

  // no answer stands without a request
  property p_no_rvalid;
    @(posedge core_clk) disable iff (rst) !dataRd |=> !cpuRvalid;
  endproperty
  a_no_rvalid: assert property (p_no_rvalid) else $error("spurious read answer");

  // read data stands until the next read
  property p_rdata_hold;
    @(posedge core_clk) disable iff (rst) !dataRd |=> $stable(cpuRdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  // open kernel call: taken in idle, armed and unprotected
  sequence s_call_open;
    (kst_r == frp_pkg::FRP_K_IDLE) && kernelStart && armed_r && !prot_r;
  endsequence
  // array operation released with a clean error code
  sequence s_array_run;
    kernelGo && (kernelErr == `FRP_ERR_NONE);
  endsequence
  property p_open_call;
    @(posedge core_clk) disable iff (rst) s_call_open |=> s_array_run;
  endproperty
  a_open_call: assert property (p_open_call) else $error("open call refused");

  // kernel completion is a single-cycle pulse
  property p_done_pulse;
    @(posedge core_clk) disable iff (rst) kernelDone |=> !kernelDone;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");

  // error code stands until the next armed call in idle, accepted or refused
  property p_err_hold;
    @(posedge core_clk) disable iff (rst)
      !((kst_r == frp_pkg::FRP_K_IDLE) && kernelStart) |=> $stable(kernelErr);
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error code moved");

  // fuse only changes through a special-mode write
  property p_fuse_gate;
    @(posedge core_clk) disable iff (rst) !(specialMode && fuseWrEn) |=> $stable(fuse_r);
  endproperty
  a_fuse_gate: assert property (p_fuse_gate) else $error("fuse written outside mode");

  // a programmed fuse never returns to the unprogrammed value
  property p_fuse_sticky;
    @(posedge core_clk) disable iff (rst) fuse_r |=> fuse_r;
  endproperty
  a_fuse_sticky: assert property (p_fuse_sticky) else $error("fuse cleared");

  // protection only falls through an accepted zero write
  property p_prot_fall;
    @(posedge core_clk) disable iff (rst) $fell(prot_r) |-> $past(unlockHit);
  endproperty
  a_prot_fall: assert property (p_prot_fall) else $error("bad protection drop");

  // protection only rises at arming after reset or at kernel end
  property p_prot_rise;
    @(posedge core_clk) disable iff (rst)
      $rose(prot_r) |-> !$past(armed_r) || $past(kernelDone);
  endproperty
  a_prot_rise: assert property (p_prot_rise) else $error("bad protection rise");
endmodule : frp_flash_read_protection
`default_nettype wire

// File: core/frp_origin.sv
// latches the region of the current instruction fetch
`timescale 1ns/1ps
`default_nettype none
`include "frp_params.svh"
module frp_origin (
  input  wire logic  core_clk,
  input  wire logic  rst,
  frp_fetch_if.cls   fif
);
  // ==========================================================
  // region decode
  function automatic logic frpInFlash(input logic [23:0] a);
    frpInFlash = (a >= `FRP_FLASH_BASE) && (a <= `FRP_FLASH_LIMIT);
  endfunction : frpInFlash

  frp_pkg::frp_origin_t origin_r;

  // remember where the last fetch came from
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      origin_r <= frp_pkg::FRP_ORG_OTHER;
    end else if (fif.fetchValid) begin
      origin_r <= frpInFlash(fif.fetchAddr) ? frp_pkg::FRP_ORG_FLASH
                                            : frp_pkg::FRP_ORG_OTHER;
    end
  end
  assign fif.origin = origin_r;
endmodule : frp_origin
`default_nettype wire

// File: core/frp_params.svh
// constants for the flash read protection block
`ifndef FRP_PARAMS_SVH
`define FRP_PARAMS_SVH
`define FRP_ADDR_W       24
`define FRP_DATA_W       16
`define FRP_FLASH_BASE   24'h000000
`define FRP_FLASH_LIMIT  24'h03FFFF
`define FRP_PROT_PATTERN 16'hB88B
`define FRP_ERR_NONE     8'h00
`define FRP_ERR_PROT     8'h01
`define FRP_FUSE_RESET   1'h0
`define FRP_BUSY_MAX     16'hFFFF
`endif

// File: core/frp_pkg.sv
// type package for the flash read protection block
`default_nettype none
package frp_pkg;
  // origin of the code that issues an access
  typedef enum logic [1:0] {
    FRP_ORG_FLASH = 2'h0,
    FRP_ORG_OTHER = 2'h1
  } frp_origin_t;
  // kernel sequencing, one-hot
  typedef enum logic [2:0] {
    FRP_K_IDLE = 3'h1,
    FRP_K_RUN  = 3'h2,
    FRP_K_DONE = 3'h4
  } frp_kstate_t;
endpackage : frp_pkg
`default_nettype wire

// File: tb/frp_flash_model.sv
// flash array and array-op timing model facing the protection block
`timescale 1ns/1ps
`default_nettype none
module frp_flash_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [23:0] dataAddr,
  input  wire logic        kernelGo,
  output logic [15:0]      flashRdata,
  output logic             kernelOpDone
);
  logic [1:0] waitCnt_r;
  // array word derived from its address
  assign flashRdata = dataAddr[15:0] ^ 16'hA5C3;
  // array op finishes four cycles after go
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      waitCnt_r    <= 2'h0;
      kernelOpDone <= 1'h0;
    end else begin
      kernelOpDone <= kernelGo && (waitCnt_r == 2'h3);
      waitCnt_r    <= kernelGo ? waitCnt_r + 2'h1 : 2'h0;
    end
  end
endmodule : frp_flash_model
`default_nettype wire

// File: tb/tb_flash_read_protection.sv
// self-checking bench for the flash read protection block
`timescale 1ns/1ps
`default_nettype none
`include "frp_params.svh"
module tb_flash_read_protection;
  logic core_clk = 0, rst = 1, fetchValid = 0, dataRd = 0, dataWr = 0;
  logic kernelStart = 0, specialMode = 0, fuseWrEn = 0, fuseWrData = 0;
  logic [23:0] fetchAddr = 0, dataAddr = 0;
  logic [15:0] dataWdata = 0, flashRdata, cpuRdata;
  logic cpuRvalid, kernelOpDone, kernelGo, kernelDone, fuseRdata, protActive;
  logic [7:0] kernelErr;
  int errCount = 0, numChecks = 0;
  // design and its flash partner
  frp_flash_read_protection i_frp_flash_read_protection (.core_clk(core_clk), .rst(rst),
    .fetchValid(fetchValid), .fetchAddr(fetchAddr), .dataRd(dataRd), .dataWr(dataWr),
    .dataAddr(dataAddr), .dataWdata(dataWdata), .flashRdata(flashRdata),
    .cpuRdata(cpuRdata), .cpuRvalid(cpuRvalid), .kernelStart(kernelStart),
    .kernelOpDone(kernelOpDone), .kernelGo(kernelGo), .kernelDone(kernelDone),
    .kernelErr(kernelErr), .specialMode(specialMode), .fuseWrEn(fuseWrEn),
    .fuseWrData(fuseWrData), .fuseRdata(fuseRdata), .protActive(protActive));
  frp_flash_model i_frp_flash_model (.core_clk(core_clk), .rst(rst), .dataAddr(dataAddr),
    .kernelGo(kernelGo), .flashRdata(flashRdata), .kernelOpDone(kernelOpDone));
  always #10 core_clk = ~core_clk;
  // helpers
  function automatic logic [15:0] arr(input logic [23:0] a);
    return a[15:0] ^ 16'hA5C3;
  endfunction : arr
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  task automatic org(input logic [23:0] a);
    fetchValid = 1; fetchAddr = a; cyc(1); fetchValid = 0; cyc(1);
  endtask : org
  task automatic rd(input logic [23:0] a, input logic [15:0] exp);
    dataAddr = a; dataRd = 1; cyc(1); dataRd = 0;
    chk("rvalid", cpuRvalid, 1);
    chk("rdata", cpuRdata, exp);
    cyc(1);
    chk("rvalid", cpuRvalid, 0);
  endtask : rd
  task automatic wr(input logic [23:0] a, input logic [15:0] d, input logic expProt);
    dataAddr = a; dataWdata = d; dataWr = 1; cyc(1); dataWr = 0; cyc(1);
    chk("prot", protActive, expProt);
  endtask : wr
  task automatic kern(input logic prot);
    kernelStart = 1; cyc(1); kernelStart = 0;
    chk("go", kernelGo, !prot);
    for (int i = 0; i < 20 && kernelDone !== 1; i++) cyc(1);
    chk("done", kernelDone, 1);
    chk("err", kernelErr, prot ? `FRP_ERR_PROT : `FRP_ERR_NONE);
    cyc(2); chk("rearm", protActive, 1);
  endtask : kern
  // scenarios
  task automatic scnFuse;
    chk("prot", protActive, 0);
    fuseWrEn = 1; fuseWrData = 1; cyc(1); fuseWrEn = 0; specialMode = 1; cyc(1);
    chk("fuse", fuseRdata, 0);
    fuseWrEn = 1; cyc(1); fuseWrEn = 0; cyc(1); chk("fuse", fuseRdata, 1);
    specialMode = 0; cyc(1); chk("fuse", fuseRdata, 0);
    org(24'h100000); rd(24'h000010, arr(24'h000010));
  endtask : scnFuse
  task automatic scnProtect;
    kern(0);
    org(24'h100000); rd(24'h000010, `FRP_PROT_PATTERN);
    rd(24'h03FFFE, `FRP_PROT_PATTERN);
    rd(24'h040000, arr(24'h040000));
    wr(24'h000010, 16'h0000, 1);
    kern(1);
    org(24'h001000); rd(24'h000020, arr(24'h000020));
    wr(24'h000011, 16'h0000, 1);
    wr(24'h000022, 16'h0001, 1);
    wr(24'h03FFFE, 16'h0000, 0);
  endtask : scnProtect
  task automatic scnUnlocked;
    org(24'h200000); rd(24'h000010, arr(24'h000010));
    kern(0);
    rd(24'h000010, `FRP_PROT_PATTERN);
  endtask : scnUnlocked
  task automatic scnReset;
    org(24'h001000); wr(24'h000100, 16'h0000, 0);
    rst = 1; cyc(2); chk("prot", protActive, 0);
    rst = 0; cyc(2); chk("prot", protActive, 1);
    specialMode = 1; cyc(1); chk("fuse", fuseRdata, 1);
    specialMode = 0; org(24'h100000); rd(24'h000010, `FRP_PROT_PATTERN);
  endtask : scnReset
  task automatic endOfTest;
    if (errCount == 0 && numChecks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : endOfTest
  // main sequence
  initial begin
    cyc(10); rst = 0; cyc(2);
    scnFuse(); scnProtect(); scnUnlocked(); scnReset();
    endOfTest();
  end
  // watchdog well beyond the fewer than a hundred cycles used
  initial begin
    #(2000 * 20);
    errCount++;
    endOfTest();
  end
endmodule : tb_flash_read_protection
`default_nettype wire
